//--- dv/ptp_mem_model.sv
// System memory model holding page directory and tables for the page unit
`timescale 1ns/100ps
module ptp_mem_model (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          mem_req,
    input  ptp_pkg::ptp_mem_s  mem,
    input  wire logic [3:0]    lag,
    output logic               mem_ack,
    output logic [31:0]        mem_rdata
);
    // ----------------------------------------------------------------
    // Storage and bookkeeping
    // ----------------------------------------------------------------
    logic [31:0] words [logic [31:0]];
    logic [3:0]  wait_cnt;
    int          n_unlocked;

    // ----------------------------------------------------------------
    // Access engine
    // ----------------------------------------------------------------
    // Idle data toggles so a late sample never sees a stale good word
    always @(posedge clk) begin
        if (reset) begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0000_0000;
            wait_cnt <= 4'h0;
        end else if (mem_req && !mem_ack && wait_cnt >= lag) begin
            mem_ack <= 1'b1;
            wait_cnt <= 4'h0;
            if (mem.write) begin
                words[mem.addr] = mem.wdata;
                mem_rdata <= ~mem_rdata;
                if (!mem.lock) n_unlocked++;
            end else begin
                mem_rdata <= words.exists(mem.addr) ? words[mem.addr] : 32'h0000_0000;
            end
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

//--- dv/tb.sv
// Self-checking testbench for the page translation and protection unit
`timescale 1ns/100ps
module tb;
    logic               clk, reset, req_valid, req_ready, resp_valid, ctl_wr_en;
    logic               tsw_load, mem_req, mem_ack, protected_mode, paging_active;
    logic [1:0]         ctl_wr_sel, ctl_rd_sel;
    logic [31:0]        ctl_wdata, ctl_rdata, tsw_dir_base, mem_rdata, rd;
    logic [3:0]         lag;
    ptp_pkg::ptp_req_s  req;
    ptp_pkg::ptp_resp_s resp, got;
    ptp_pkg::ptp_mem_s  mem;
    int                 n_mismatch, total_checks;
    localparam logic [31:0] DIR_A = 32'h0001_0000;
    localparam logic [31:0] DIR_B = 32'h0003_0000;

    ptp_page_unit dut_u (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp),
        .ctl_wr_en(ctl_wr_en), .ctl_wr_sel(ctl_wr_sel), .ctl_wdata(ctl_wdata),
        .ctl_rd_sel(ctl_rd_sel), .ctl_rdata(ctl_rdata), .tsw_load(tsw_load),
        .tsw_dir_base(tsw_dir_base), .mem_req(mem_req), .mem(mem), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .protected_mode(protected_mode),
        .paging_active(paging_active));
    ptp_mem_model mem_u (.clk(clk), .reset(reset), .mem_req(mem_req), .mem(mem),
        .lag(lag), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic ctl_write(input logic [1:0] sel, input logic [31:0] data);
        @(posedge clk);
        ctl_wr_en <= 1'b1;
        ctl_wr_sel <= sel;
        ctl_wdata <= data;
        @(posedge clk);
        ctl_wr_en <= 1'b0;
        // The write lands on this edge; look at the mode outputs once they settle
        @(negedge clk);
    endtask

    task automatic ctl_read(input logic [1:0] sel);
        @(posedge clk);
        ctl_rd_sel <= sel;
        @(posedge clk);
        @(negedge clk);
        rd = ctl_rdata;
    endtask

    task automatic translate(input logic [31:0] lin, input logic w, input logic [1:0] c);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{linear: lin, write: w, cpl: c};
        n = 0;
        do begin @(negedge clk); n++; end while (req_ready !== 1'b1 && n < 100);
        if (req_ready !== 1'b1) begin
            n_mismatch++;
            test_done();
        end
        @(posedge clk);
        req_valid <= 1'b0;
        do begin @(negedge clk); n++; end while (resp_valid !== 1'b1 && n < 300);
        if (n >= 300) begin
            n_mismatch++;
            test_done();
        end
        got = resp;
    endtask

    task automatic map(input logic [31:0] base, lin, pde, pte);
        mem_u.words[base + {20'h0_0000, lin[31:22], 2'b00}] = pde;
        mem_u.words[{pde[31:12], 12'h000} + {20'h0_0000, lin[21:12], 2'b00}] = pte;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_and_control();
        check(32'(protected_mode), 32'h0, "mode after reset");
        ctl_read(ptp_pkg::SEL_DIRECTORY_BASE);
        check(rd, 32'h0, "base after reset");
        translate(32'h1234_5678, 1'b1, 2'h3);
        check(got.phys, 32'h1234_5678, "unpaged phys");
        ctl_write(ptp_pkg::SEL_MACHINE_CONTROL, 32'h0000_0001);
        check({31'h0, protected_mode}, 32'h1, "protected");
        check({31'h0, paging_active}, 32'h0, "paging still off");
        ctl_write(ptp_pkg::SEL_DIRECTORY_BASE, 32'hABCD_E123);
        ctl_read(ptp_pkg::SEL_DIRECTORY_BASE);
        check(rd, 32'hABCD_E000, "base low bits");
        ctl_write(ptp_pkg::SEL_FAULT_ADDRESS, 32'h5555_AAAA);
        ctl_read(ptp_pkg::SEL_FAULT_ADDRESS);
        check(rd, 32'h5555_AAAA, "fault address rw");
        ctl_write(ptp_pkg::SEL_DIRECTORY_BASE, DIR_A);
        ctl_write(ptp_pkg::SEL_MACHINE_CONTROL, 32'h8000_0001);
        check({31'h0, paging_active}, 32'h1, "paging on");
    endtask

    // Slow memory walk, then a write that must set the dirty flag
    task automatic t_walk();
        lag = 4'h3;
        map(DIR_A, 32'h0040_3ABC, 32'h0002_0E07, 32'h0005_5E07);
        translate(32'h0040_3ABC, 1'b0, 2'h0);
        check(got.phys, 32'h0005_5ABC, "walk phys");
        check(mem_u.words[DIR_A + 32'h4], 32'h0002_0E27, "dir accessed");
        check(mem_u.words[32'h0002_000C], 32'h0005_5E27, "table accessed");
        translate(32'h0040_3004, 1'b1, 2'h0);
        check(got.phys, 32'h0005_5004, "write phys");
        check(mem_u.words[32'h0002_000C], 32'h0005_5E67, "table dirty");
        check(32'(mem_u.n_unlocked), 32'h0, "unlocked writes");
        lag = 4'h0;
    endtask

    // Case code: dir rights, table rights, user, write, wp, fault
    task automatic t_protect();
        logic [7:0]  cs [8];
        logic [31:0] lin;
        cs = '{8'b11_01_1001, 8'b11_10_1101, 8'b11_10_1000, 8'b11_00_0100,
               8'b11_00_0111, 8'b10_11_1101, 8'b10_01_1001, 8'b11_11_1110};
        for (int i = 0; i < 8; i++) begin
            lin = {10'(8 + i), 10'(i), 12'h100};
            map(DIR_A, lin, {20'h0_0060 + 20'(i), 9'h0, cs[i][7:6], 1'b1},
                {20'h0_0070 + 20'(i), 9'h0, cs[i][5:4], 1'b1});
            ctl_write(ptp_pkg::SEL_MACHINE_CONTROL, {1'b1, 14'h0, cs[i][1], 16'h0001});
            translate(lin, cs[i][2], cs[i][3] ? 2'h3 : 2'h2);
            check(32'(got.fault), 32'(cs[i][0]), "fault flag");
            if (cs[i][0]) begin
                check(32'(got.vector), 32'h0000_000E, "vector");
                ctl_read(ptp_pkg::SEL_FAULT_ADDRESS);
                check(rd, lin, "fault address");
            end else begin
                check(got.phys, {20'h0_0070 + 20'(i), 12'h100}, "granted phys");
            end
        end
        ctl_write(ptp_pkg::SEL_MACHINE_CONTROL, 32'h8000_0001);
    endtask

    task automatic t_absent();
        map(DIR_A, 32'h0100_0000, 32'hFFFF_FFFE, 32'h0);
        translate(32'h0100_0000, 1'b0, 2'h0);
        check({30'h0, got.fault, got.not_present}, 32'h3, "dir absent");
        check(mem_u.words[DIR_A + 32'h10], 32'hFFFF_FFFE, "absent dir kept");
        map(DIR_A, 32'h0140_2000, 32'h0009_0027, 32'h1234_5FFE);
        translate(32'h0140_2000, 1'b1, 2'h0);
        check({30'h0, got.fault, got.not_present}, 32'h3, "table absent");
        check(mem_u.words[32'h0009_0008], 32'h1234_5FFE, "absent table kept");
    endtask

    task automatic t_flush();
        translate(32'h0040_3ABC, 1'b0, 2'h0);
        mem_u.words[32'h0002_000C] = 32'h0006_6E67;
        ctl_write(ptp_pkg::SEL_DIRECTORY_BASE, DIR_A);
        translate(32'h0040_3ABC, 1'b0, 2'h0);
        check(got.phys, 32'h0006_6ABC, "flush on base write");
        map(DIR_B, 32'h0040_3ABC, 32'h000A_0027, 32'h0007_7067);
        @(posedge clk);
        tsw_load <= 1'b1;
        tsw_dir_base <= DIR_B;
        @(posedge clk);
        tsw_load <= 1'b0;
        ctl_read(ptp_pkg::SEL_DIRECTORY_BASE);
        check(rd, DIR_B, "task switch base");
        translate(32'h0040_3ABC, 1'b0, 2'h0);
        check(got.phys, 32'h0007_7ABC, "flush on task switch");
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        reset = 1'b1;
        req_valid = 1'b0;
        req = '0;
        ctl_wr_en = 1'b0;
        ctl_wr_sel = 2'h0;
        ctl_wdata = 32'h0;
        ctl_rd_sel = 2'h0;
        tsw_load = 1'b0;
        tsw_dir_base = 32'h0;
        lag = 4'h0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_reset_and_control();
        t_walk();
        t_protect();
        t_absent();
        t_flush();
        test_done();
    end
endmodule

//--- logic/ptp_page_unit.sv
// Two-level page translation, protection check and table entry update
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/100ps
module ptp_page_unit (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              req_valid,
    input  ptp_pkg::ptp_req_s      req,
    output logic                   req_ready,
    output logic                   resp_valid,
    output ptp_pkg::ptp_resp_s     resp,
    input  wire logic              ctl_wr_en,
    input  wire logic [1:0]        ctl_wr_sel,
    input  wire logic [31:0]       ctl_wdata,
    input  wire logic [1:0]        ctl_rd_sel,
    output logic [31:0]            ctl_rdata,
    input  wire logic              tsw_load,
    input  wire logic [31:0]       tsw_dir_base,
    output logic                   mem_req,
    output ptp_pkg::ptp_mem_s      mem,
    input  wire logic              mem_ack,
    input  wire logic [31:0]       mem_rdata,
    output logic                   protected_mode,
    output logic                   paging_active
);

    typedef struct packed {
        ptp_pkg::ptp_state_e st;
        ptp_pkg::ptp_req_s   req;
        logic [31:0]         pde;
        logic [31:0]         pte;
        logic                resp_valid;
        ptp_pkg::ptp_resp_s  resp;
        logic                mem_req;
        ptp_pkg::ptp_mem_s   mem;
        logic                pe;
        logic                pg;
        logic                wp;
        logic [31:0]         fault_addr;
        logic [19:0]         dir_base;
        logic [31:0]         rdata;
        ptp_pkg::ptp_tlb_s [ptp_pkg::TLB_N-1:0] tlb;
    } ptp_unit_s;

    ptp_unit_s s_reg;
    ptp_unit_s s_next;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // level map, permission table
    function automatic logic prot_fault(logic [1:0] rights, logic wr, logic [1:0] cpl,
                                        logic wp);
        logic user;
        user = (cpl == ptp_pkg::USER_LEVEL);
        if (user) begin
            prot_fault = !rights[1] || (wr && !rights[0]);
        end else begin
            prot_fault = wr && wp && !rights[0];
        end
    endfunction

    function automatic logic [1:0] min_rights(logic [1:0] a, logic [1:0] b);
        min_rights = (a < b) ? a : b;
    endfunction

    function automatic ptp_unit_s do_fault(ptp_unit_s x, logic np);
        x.resp_valid       = 1'b1;
        x.resp.fault       = 1'b1;
        x.resp.not_present = np;
        x.resp.vector      = ptp_pkg::PAGE_FAULT_VEC;
        x.resp.phys        = 32'h0000_0000;
        x.fault_addr       = x.req.linear;
        x.mem_req          = 1'b0;
        x.mem.lock         = 1'b0;
        x.st               = ptp_pkg::ST_IDLE;
        return x;
    endfunction

    function automatic ptp_unit_s do_done(ptp_unit_s x, logic [31:0] phys);
        x.resp_valid       = 1'b1;
        x.resp.fault       = 1'b0;
        x.resp.not_present = 1'b0;
        x.resp.vector      = 8'h00;
        x.resp.phys        = phys;
        x.mem_req          = 1'b0;
        x.mem.lock         = 1'b0;
        x.st               = ptp_pkg::ST_IDLE;
        return x;
    endfunction

    // table entry fetch, locked so a flag update can follow
    function automatic ptp_unit_s start_tbl(ptp_unit_s x, logic [31:0] pde);
        x.mem_req    = 1'b1;
        x.mem.addr   = {pde[31:12], x.req.linear[21:12], 2'b00};
        x.mem.write  = 1'b0;
        x.mem.lock   = 1'b1;
        x.st         = ptp_pkg::ST_TBL_RD;
        return x;
    endfunction

    logic [1:0]  idx;
    logic [1:0]  rights;
    logic [31:0] upd;

    always_comb begin
        s_next            = s_reg;
        s_next.resp_valid = 1'b0;
        idx               = req.linear[13:12];
        rights            = min_rights(s_reg.pde[2:1], mem_rdata[2:1]);
        upd               = 32'h0000_0000;

        // ------------------------------------------------------------
        // Control registers; hardware fault capture below wins over software
        // ------------------------------------------------------------
        if (ctl_wr_en) begin
            case (ctl_wr_sel)
                ptp_pkg::SEL_MACHINE_CONTROL: begin
                    s_next.pe = ctl_wdata[ptp_pkg::MCTL_PE_BIT];
                    s_next.pg = ctl_wdata[ptp_pkg::MCTL_PG_BIT];
                    s_next.wp = ctl_wdata[ptp_pkg::MCTL_WP_BIT];
                end
                ptp_pkg::SEL_FAULT_ADDRESS:  s_next.fault_addr = ctl_wdata;
                ptp_pkg::SEL_DIRECTORY_BASE: s_next.dir_base = ctl_wdata[31:12];
                default: ;
            endcase
        end
        if (tsw_load) begin
            s_next.dir_base = tsw_dir_base[31:12];
        end

        // ------------------------------------------------------------
        // Walk machine
        // ------------------------------------------------------------
        case (s_reg.st)
            ptp_pkg::ST_IDLE: begin
                if (req_valid) begin
                    s_next.req = req;
                    if (!(s_reg.pe && s_reg.pg)) begin
                        s_next = do_done(s_next, req.linear);
                    end else if (s_reg.tlb[idx].valid &&
                                 s_reg.tlb[idx].tag == req.linear[31:12] &&
                                 (!req.write || s_reg.tlb[idx].dirty)) begin
                        if (prot_fault(s_reg.tlb[idx].rights, req.write, req.cpl, s_reg.wp)) begin
                            s_next = do_fault(s_next, 1'b0);
                        end else begin
                            s_next = do_done(s_next, {s_reg.tlb[idx].frame, req.linear[11:0]});
                        end
                    end else begin
                        s_next.mem_req   = 1'b1;
                        s_next.mem.addr  = {s_reg.dir_base, req.linear[31:22], 2'b00};
                        s_next.mem.write = 1'b0;
                        s_next.mem.lock  = 1'b1;
                        s_next.st        = ptp_pkg::ST_DIR_RD;
                    end
                end
            end
            ptp_pkg::ST_DIR_RD: begin
                if (mem_ack) begin
                    s_next.pde = mem_rdata;
                    if (!mem_rdata[ptp_pkg::ENT_P_BIT]) begin
                        s_next = do_fault(s_next, 1'b1);
                    end else if (!mem_rdata[ptp_pkg::ENT_A_BIT]) begin
                        // locked write back, other bits untouched
                        s_next.mem.wdata = mem_rdata | (32'h0000_0001 << ptp_pkg::ENT_A_BIT);
                        s_next.mem.write = 1'b1;
                        s_next.pde       = s_next.mem.wdata;
                        s_next.st        = ptp_pkg::ST_DIR_WR;
                    end else begin
                        s_next = start_tbl(s_next, mem_rdata);
                    end
                end
            end
            ptp_pkg::ST_DIR_WR: begin
                if (mem_ack) begin
                    s_next = start_tbl(s_next, s_reg.pde);
                end
            end
            ptp_pkg::ST_TBL_RD: begin
                if (mem_ack) begin
                    upd = mem_rdata | (32'h0000_0001 << ptp_pkg::ENT_A_BIT);
                    if (s_reg.req.write) begin
                        upd = upd | (32'h0000_0001 << ptp_pkg::ENT_D_BIT);
                    end
                    s_next.pte = upd;
                    if (!mem_rdata[ptp_pkg::ENT_P_BIT]) begin
                        s_next = do_fault(s_next, 1'b1);
                    end else if (prot_fault(rights, s_reg.req.write, s_reg.req.cpl, s_reg.wp)) begin
                        s_next = do_fault(s_next, 1'b0);
                    end else if (upd != mem_rdata) begin
                        s_next.mem.wdata = upd;
                        s_next.mem.write = 1'b1;
                        s_next.st        = ptp_pkg::ST_TBL_WR;
                    end else begin
                        s_next.st = ptp_pkg::ST_TBL_WR;
                        s_next.mem_req = 1'b0;
                    end
                end
            end
            ptp_pkg::ST_TBL_WR: begin
                if (mem_ack || !s_reg.mem_req) begin
                    s_next.tlb[s_reg.req.linear[13:12]] = '{
                        valid:  1'b1,
                        tag:    s_reg.req.linear[31:12],
                        frame:  s_reg.pte[31:12],
                        rights: min_rights(s_reg.pde[2:1], s_reg.pte[2:1]),
                        dirty:  s_reg.pte[ptp_pkg::ENT_D_BIT]
                    };
                    s_next = do_done(s_next, {s_reg.pte[31:12], s_reg.req.linear[11:0]});
                end
            end
            default: s_next.st = ptp_pkg::ST_IDLE;
        endcase

        // flush; after the fill so a stale fill cannot survive
        if ((ctl_wr_en && ctl_wr_sel == ptp_pkg::SEL_DIRECTORY_BASE) ||
            (tsw_load && tsw_dir_base[31:12] != s_reg.dir_base)) begin
            for (int i = 0; i < ptp_pkg::TLB_N; i++) begin
                s_next.tlb[i].valid = 1'b0;
            end
        end

        case (ctl_rd_sel)
            ptp_pkg::SEL_MACHINE_CONTROL: begin
                s_next.rdata = 32'h0000_0000;
                s_next.rdata[ptp_pkg::MCTL_PE_BIT] = s_reg.pe;
                s_next.rdata[ptp_pkg::MCTL_WP_BIT] = s_reg.wp;
                s_next.rdata[ptp_pkg::MCTL_PG_BIT] = s_reg.pg;
            end
            ptp_pkg::SEL_FAULT_ADDRESS:  s_next.rdata = s_reg.fault_addr;
            ptp_pkg::SEL_DIRECTORY_BASE: s_next.rdata = {s_reg.dir_base, 12'h000};
            default:                     s_next.rdata = 32'h0000_0000;
        endcase
    end

    // reset leaves every mode bit clear
    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg          <= '0;
            s_reg.dir_base <= ptp_pkg::DIRB_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign req_ready      = (s_reg.st == ptp_pkg::ST_IDLE);
    assign resp_valid     = s_reg.resp_valid;
    assign resp           = s_reg.resp;
    assign ctl_rdata      = s_reg.rdata;
    assign mem_req        = s_reg.mem_req;
    assign mem            = s_reg.mem;
    assign protected_mode = s_reg.pe;
    assign paging_active  = s_reg.pe && s_reg.pg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence q_dir_absent;
        s_reg.st == ptp_pkg::ST_DIR_RD && mem_ack && !mem_rdata[0];
    endsequence
    sequence q_fault_resp;
        resp_valid && resp.fault && resp.not_present;
    endsequence

    property p_real_after_reset;
        @(posedge clk) reset |=> !protected_mode && !paging_active;
    endproperty
    a_real_after_reset: assert property (p_real_after_reset) else $error("mode set after reset");

    property p_pe_enter;
        @(posedge clk) disable iff (reset)
        ctl_wr_en && ctl_wr_sel == 2'h0 && ctl_wdata[0] |=> protected_mode;
    endproperty
    a_pe_enter: assert property (p_pe_enter) else $error("enable write ignored");

    property p_fault_addr;
        @(posedge clk) disable iff (reset)
        resp_valid && resp.fault |-> s_reg.fault_addr == s_reg.req.linear;
    endproperty
    a_fault_addr: assert property (p_fault_addr) else $error("fault address not held");

    property p_base_low_zero;
        @(posedge clk) disable iff (reset)
        ctl_rd_sel == 2'h3 |=> ctl_rdata[11:0] == 12'h000;
    endproperty
    a_base_low_zero: assert property (p_base_low_zero) else $error("base low bits set");

    property p_flush;
        @(posedge clk) disable iff (reset)
        ctl_wr_en && ctl_wr_sel == 2'h3 |=> s_reg.tlb[0].valid == 1'b0 && !s_reg.tlb[3].valid;
    endproperty
    a_flush: assert property (p_flush) else $error("cache not flushed");

    property p_dir_index;
        @(posedge clk) disable iff (reset)
        mem_req && s_reg.st == ptp_pkg::ST_DIR_RD |-> mem.addr[11:2] == s_reg.req.linear[31:22];
    endproperty
    a_dir_index: assert property (p_dir_index) else $error("directory index wrong");

    property p_tbl_index;
        @(posedge clk) disable iff (reset)
        mem_req && s_reg.st == ptp_pkg::ST_TBL_RD |-> mem.addr[11:2] == s_reg.req.linear[21:12];
    endproperty
    a_tbl_index: assert property (p_tbl_index) else $error("table index wrong");

    property p_offset;
        @(posedge clk) disable iff (reset)
        resp_valid && !resp.fault |-> resp.phys[11:0] == s_reg.req.linear[11:0];
    endproperty
    a_offset: assert property (p_offset) else $error("offset altered");

    property p_locked_update;
        @(posedge clk) disable iff (reset)
        mem_req && mem.write |-> mem.lock && $past(mem.lock);
    endproperty
    a_locked_update: assert property (p_locked_update) else $error("unlocked update");

    property p_absent_fault;
        @(posedge clk) disable iff (reset) q_dir_absent |=> q_fault_resp;
    endproperty
    a_absent_fault: assert property (p_absent_fault) else $error("absent entry no fault");

endmodule

//--- logic/ptp_pkg.sv
// Shared constants and carrier types for the page translation and protection unit
package ptp_pkg;

    // ----------------------------------------------------------------
    // Widths and address split
    // ----------------------------------------------------------------
    localparam int ADDR_W     = 32;
    localparam int OFS_W      = 12;
    localparam int IDX_W      = 10;
    localparam int FRAME_W    = ADDR_W - OFS_W;
    localparam int TLB_IDX_W  = 2;
    localparam int TLB_N      = 1 << TLB_IDX_W;

    // ----------------------------------------------------------------
    // Control register selects
    // ----------------------------------------------------------------
    localparam logic [1:0] SEL_MACHINE_CONTROL = 2'h0;
    localparam logic [1:0] SEL_FAULT_ADDRESS   = 2'h2;
    localparam logic [1:0] SEL_DIRECTORY_BASE  = 2'h3;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int MCTL_PE_BIT = 0;
    localparam int MCTL_WP_BIT = 16;
    localparam int MCTL_PG_BIT = 31;
    localparam int ENT_P_BIT   = 0;
    localparam int ENT_RW_BIT  = 1;
    localparam int ENT_US_BIT  = 2;
    localparam int ENT_A_BIT   = 5;
    localparam int ENT_D_BIT   = 6;

    // ----------------------------------------------------------------
    // Fixed values
    // ----------------------------------------------------------------
    localparam logic [1:0]  USER_LEVEL      = 2'h3;
    localparam logic [7:0]  PAGE_FAULT_VEC  = 8'h0e;
    localparam logic [31:0] MCTL_RESET      = 32'h0000_0000;
    localparam logic [31:0] FAULT_RESET     = 32'h0000_0000;
    localparam logic [19:0] DIRB_RESET      = 20'h0_0000;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_DIR_RD = 3'b001,
        ST_DIR_WR = 3'b010,
        ST_TBL_RD = 3'b011,
        ST_TBL_WR = 3'b100
    } ptp_state_e;

    typedef struct packed {
        logic [31:0] linear;
        logic        write;
        logic [1:0]  cpl;
    } ptp_req_s;

    typedef struct packed {
        logic [31:0] phys;
        logic        fault;
        logic        not_present;
        logic [7:0]  vector;
    } ptp_resp_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        write;
        logic        lock;
    } ptp_mem_s;

    typedef struct packed {
        logic        valid;
        logic [19:0] tag;
        logic [19:0] frame;
        logic [1:0]  rights;
        logic        dirty;
    } ptp_tlb_s;

endpackage
